// [hw/dism_pkg.sv]
// Purpose: Shared constants and carriers for the DMA interrupt source multiplexer.
// Assumes: 16-bit memory-mapped register space on the processor clock.
// Notes:   The route-select field position is a local placement choice.
package dism_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_WIDTH        = 16;
  localparam int          DATA_WIDTH        = 16;
  localparam logic [15:0] PREC_CTRL_OFFSET  = 16'h0054;
  localparam logic [15:0] PREC_CTRL_RESET   = 16'h0000;
  localparam int          ROUTE_SEL_LSB     = 6;
  localparam int          ROUTE_SEL_WIDTH   = 2;
  localparam int          DMA_CHANNELS      = 6;

  // Processor flag and mask bit positions that are shared
  localparam int          POS_CH0_SHARED    = 6;
  localparam int          POS_CH1_SHARED    = 7;
  localparam int          POS_CH2_SHARED    = 10;
  localparam int          POS_CH3_SHARED    = 11;

  // ----------------------------------------------------------------
  // Route-select encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ROUTE_LEGACY     = 2'h0,
    ROUTE_SERIAL_DMA = 2'h1,
    ROUTE_ALL_DMA    = 2'h2,
    ROUTE_RESERVED   = 2'h3
  } dism_route_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reserved_irq;
    logic timer1_irq;
    logic serial1_rx_irq;
    logic serial1_tx_irq;
  } dism_legacy_type;

  typedef struct packed {
    logic pos6;
    logic pos7;
    logic pos10;
    logic pos11;
  } dism_shared_type;

endpackage

// [hw/dism_route_cell.sv]
// Purpose: One shared interrupt position: picks the legacy or the DMA source.
// Assumes: Both sources are on mclk; no synchroniser needed.
// Notes:   Output is registered so the top drives it straight from a flop.
`timescale 1ns/1ps

module dism_route_cell (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic use_dma,
  input  wire logic legacy_irq,
  input  wire logic dma_irq,
  output logic      irq_out
);

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_out <= 1'h0;
    end else if (ce) begin
      irq_out <= use_dma ? dma_irq : legacy_irq;
    end
  end

endmodule

// [hw/dism_top.sv]
// Purpose: Routes DMA channels 0 to 3 onto processor flag positions; channels 4 and 5 have own outputs.
// Assumes: Requests are same-clock pulses or levels; far side latches flags.
// Notes:   Reset acts even while ce is low; all other state freezes on ce low.
//
// Summary of operation
// - Each of six DMA channels yields its own processor interrupt request when route select is 10b.
// - DMA channels 2 and 3 may take flag positions 10 and 11.
// - DMA channel 1 may take flag position 7 from timer 1.
// - DMA channel 0 may take flag position 6 from the reserved source.
// - Reset clears route select to 00b, giving only legacy sources.
// - 01b routes channels 2,3; 10b routes channels 0 to 3; 11b reserved.
`timescale 1ns/1ps

module dism_top (
  input  wire logic                           mclk,
  input  wire logic                           reset,
  input  wire logic                           ce,
  input  wire logic [dism_pkg::ADDR_WIDTH-1:0] mmr_addr,
  input  wire logic                           mmr_wr,
  input  wire logic                           mmr_rd,
  input  wire logic [dism_pkg::DATA_WIDTH-1:0] mmr_wdata,
  output logic      [dism_pkg::DATA_WIDTH-1:0] mmr_rdata,
  input  wire logic [dism_pkg::DMA_CHANNELS-1:0] dma_ch_irq,
  input  wire dism_pkg::dism_legacy_type      legacy_irq,
  output dism_pkg::dism_shared_type           shared_irq,
  output logic                                dma_ch4_req,
  output logic                                dma_ch5_req,
  output dism_pkg::dism_route_type            route_active
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [dism_pkg::DATA_WIDTH-1:0]      dma_priority_enable_control;
  logic [dism_pkg::ROUTE_SEL_WIDTH-1:0] dma_irq_route_select;
  logic                                 reg_hit;
  logic                                 route_dma_hi;
  logic                                 route_dma_lo;
  dism_pkg::dism_route_type             next_route;

  assign reg_hit              = (mmr_addr == dism_pkg::PREC_CTRL_OFFSET);
  assign dma_irq_route_select =
    dma_priority_enable_control[dism_pkg::ROUTE_SEL_LSB +: dism_pkg::ROUTE_SEL_WIDTH];

  // Other bits are stored for the priority and enable logic elsewhere
  always_ff @(posedge mclk) begin
    if (reset) begin
      dma_priority_enable_control <= dism_pkg::PREC_CTRL_RESET;
    end else if (ce && mmr_wr && reg_hit) begin
      dma_priority_enable_control <= mmr_wdata;
    end
  end

  // Read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      mmr_rdata <= '0;
    end else if (ce && mmr_rd) begin
      mmr_rdata <= reg_hit ? dma_priority_enable_control : '0;
    end
  end

  // ----------------------------------------------------------------
  // Route decode
  // ----------------------------------------------------------------
  // Reserved code falls back to legacy so a stray write cannot steal
  // timer or serial interrupts from running software.
  always_comb begin
    case (dma_irq_route_select)
      dism_pkg::ROUTE_LEGACY:     next_route = dism_pkg::ROUTE_LEGACY;
      dism_pkg::ROUTE_SERIAL_DMA: next_route = dism_pkg::ROUTE_SERIAL_DMA;
      dism_pkg::ROUTE_ALL_DMA:    next_route = dism_pkg::ROUTE_ALL_DMA;
      default:                    next_route = dism_pkg::ROUTE_LEGACY;
    endcase
  end

  assign route_dma_hi = (next_route == dism_pkg::ROUTE_SERIAL_DMA) ||
                        (next_route == dism_pkg::ROUTE_ALL_DMA);
  assign route_dma_lo = (next_route == dism_pkg::ROUTE_ALL_DMA);

  always_ff @(posedge mclk) begin
    if (reset) begin
      route_active <= dism_pkg::ROUTE_LEGACY;
    end else if (ce) begin
      route_active <= next_route;
    end
  end

  // ----------------------------------------------------------------
  // Shared positions
  // ----------------------------------------------------------------
  dism_route_cell u_pos6 (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .use_dma    (route_dma_lo),
    .legacy_irq (legacy_irq.reserved_irq),
    .dma_irq    (dma_ch_irq[0]),
    .irq_out    (shared_irq.pos6)
  );

  dism_route_cell u_pos7 (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .use_dma    (route_dma_lo),
    .legacy_irq (legacy_irq.timer1_irq),
    .dma_irq    (dma_ch_irq[1]),
    .irq_out    (shared_irq.pos7)
  );

  dism_route_cell u_pos10 (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .use_dma    (route_dma_hi),
    .legacy_irq (legacy_irq.serial1_rx_irq),
    .dma_irq    (dma_ch_irq[2]),
    .irq_out    (shared_irq.pos10)
  );

  dism_route_cell u_pos11 (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .use_dma    (route_dma_hi),
    .legacy_irq (legacy_irq.serial1_tx_irq),
    .dma_irq    (dma_ch_irq[3]),
    .irq_out    (shared_irq.pos11)
  );

  // ----------------------------------------------------------------
  // Unshared channels
  // ----------------------------------------------------------------
  // Same one-cycle latency as the shared positions keeps all six aligned
  always_ff @(posedge mclk) begin
    if (reset) begin
      dma_ch4_req <= 1'h0;
      dma_ch5_req <= 1'h0;
    end else if (ce) begin
      dma_ch4_req <= dma_ch_irq[4];
      dma_ch5_req <= dma_ch_irq[5];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_route_clear: assert property (
    @(posedge mclk) reset |=> (dma_irq_route_select == 2'h0) && !shared_irq.pos6 &&
                              !shared_irq.pos7 && !shared_irq.pos10 && !shared_irq.pos11)
    else $error("route select or shared outputs not cleared by reset");

  chk_route_write_takes: assert property (
    @(posedge mclk) disable iff (reset)
    (ce && mmr_wr && reg_hit) |=>
      dma_irq_route_select ==
        $past(mmr_wdata[dism_pkg::ROUTE_SEL_LSB +: dism_pkg::ROUTE_SEL_WIDTH]))
    else $error("route select write not stored");

  // Only a hit on the control offset may change the stored word
  chk_stray_write_ignored: assert property (
    @(posedge mclk) disable iff (reset)
    !(ce && mmr_wr && reg_hit) |=> $stable(dma_priority_enable_control))
    else $error("control register changed without a write to its offset");

  chk_read_returns_reg: assert property (
    @(posedge mclk) disable iff (reset)
    (ce && mmr_rd && reg_hit) |=> mmr_rdata == $past(dma_priority_enable_control))
    else $error("read of the control register returned a different word");

  chk_read_answer_holds: assert property (
    @(posedge mclk) disable iff (reset)
    !(ce && mmr_rd) |=> $stable(mmr_rdata))
    else $error("read data changed without a read");

  chk_pos10_dma_path: assert property (
    @(posedge mclk) disable iff (reset)
    (ce && (dma_irq_route_select == 2'h1 || dma_irq_route_select == 2'h2)) |=>
      (shared_irq.pos10 == $past(dma_ch_irq[2])) &&
      (shared_irq.pos11 == $past(dma_ch_irq[3])))
    else $error("positions 10 and 11 do not follow DMA channels 2 and 3");

  chk_pos7_timer_kept: assert property (
    @(posedge mclk) disable iff (reset)
    (ce && dma_irq_route_select != 2'h2) |=>
      shared_irq.pos7 == $past(legacy_irq.timer1_irq))
    else $error("position 7 lost timer 1 outside full DMA routing");

  chk_pos6_reserved_kept: assert property (
    @(posedge mclk) disable iff (reset)
    (ce && dma_irq_route_select != 2'h2) |=>
      shared_irq.pos6 == $past(legacy_irq.reserved_irq))
    else $error("position 6 lost the reserved source outside full DMA routing");

  chk_pos67_dma_path: assert property (
    @(posedge mclk) disable iff (reset)
    (ce && dma_irq_route_select == 2'h2) |=>
      (shared_irq.pos6 == $past(dma_ch_irq[0])) &&
      (shared_irq.pos7 == $past(dma_ch_irq[1])))
    else $error("positions 6 and 7 do not follow DMA channels 0 and 1");

  chk_reserved_is_legacy: assert property (
    @(posedge mclk) disable iff (reset)
    (ce && (dma_irq_route_select == 2'h3 || dma_irq_route_select == 2'h0)) |=>
      (shared_irq.pos6 == $past(legacy_irq.reserved_irq)) &&
      (shared_irq.pos10 == $past(legacy_irq.serial1_rx_irq)) &&
      (shared_irq.pos11 == $past(legacy_irq.serial1_tx_irq)) &&
      (route_active == dism_pkg::ROUTE_LEGACY))
    else $error("legacy or reserved route let a DMA source through");

  chk_ch45_direct: assert property (
    @(posedge mclk) disable iff (reset)
    ce |=> (dma_ch4_req == $past(dma_ch_irq[4])) &&
           (dma_ch5_req == $past(dma_ch_irq[5])))
    else $error("channel 4 or 5 request not forwarded in one cycle");

  chk_freeze_on_ce: assert property (
    @(posedge mclk) disable iff (reset)
    !ce |=> $stable(shared_irq) && $stable(dma_ch4_req) && $stable(dma_ch5_req) &&
            $stable(route_active) && $stable(mmr_rdata) &&
            $stable(dma_priority_enable_control))
    else $error("outputs changed while clock enable low");

endmodule

// [test/dism_flag_model.sv]
// Purpose: Processor flag logic facing the shared interrupt positions.
// Assumes: Any high sample sets its flag; ack clears all flags.
// Notes:   Mask gates only the pending summary, never the flags.
`timescale 1ns/1ps

module dism_flag_model (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire dism_pkg::dism_shared_type shared_irq,
  input  wire logic [15:0]               mask,
  input  wire logic                      ack,
  output logic      [15:0]               flags,
  output logic                           pending
);
  always_ff @(posedge mclk) begin
    if (reset || ack) begin
      flags <= 16'h0000;
    end else begin
      // Sticky, so a one-cycle request is not lost
      flags[6]  <= flags[6] | shared_irq.pos6;
      flags[7]  <= flags[7] | shared_irq.pos7;
      flags[10] <= flags[10] | shared_irq.pos10;
      flags[11] <= flags[11] | shared_irq.pos11;
    end
  end
  assign pending = |(flags & mask);
endmodule

// [test/dism_top_tb.sv]
// Purpose: Self-checking bench for the DMA interrupt source multiplexer.
// Assumes: Inputs change 2 ns after the rising edge of mclk.
// Notes:   Table rows cover every route code; edge cases follow.
`timescale 1ns/1ps

module dism_top_tb;
  typedef struct packed {
    logic [1:0] rt;
    logic [5:0] dma;
    logic [3:0] leg;
    logic [3:0] exp;
  } dism_row_type;
  logic                      mclk = 1'b0;
  logic                      reset = 1'b1;
  logic                      ce = 1'b1;
  logic [15:0]               mmr_addr = 16'h0000;
  logic                      mmr_wr = 1'b0;
  logic                      mmr_rd = 1'b0;
  logic [15:0]               mmr_wdata = 16'h0000;
  logic [15:0]               mmr_rdata;
  logic [5:0]                dma_ch_irq = 6'h00;
  dism_pkg::dism_legacy_type legacy_irq = 4'h0;
  dism_pkg::dism_shared_type shared_irq;
  logic                      dma_ch4_req;
  logic                      dma_ch5_req;
  dism_pkg::dism_route_type  route_active;
  logic                      ack = 1'b0;
  logic [15:0]               flags;
  logic                      pending;
  logic [15:0]               wdat;
  int                        n_mismatch = 0;
  int                        tests_run = 0;
  dism_row_type              rows [8] = '{
    {2'h0, 6'h3F, 4'h0, 4'h0}, {2'h0, 6'h00, 4'hF, 4'hF},
    {2'h1, 6'h1F, 4'h0, 4'h3}, {2'h1, 6'h20, 4'hF, 4'hC},
    {2'h2, 6'h0F, 4'h0, 4'hF}, {2'h2, 6'h30, 4'hF, 4'h0},
    {2'h3, 6'h2F, 4'h0, 4'h0}, {2'h3, 6'h10, 4'hF, 4'hF}};

  always #12.5 mclk = ~mclk;

  dism_top dut_u (.mclk, .reset, .ce, .mmr_addr, .mmr_wr, .mmr_rd, .mmr_wdata, .mmr_rdata,
    .dma_ch_irq, .legacy_irq, .shared_irq, .dma_ch4_req, .dma_ch5_req, .route_active);
  dism_flag_model model_u (.mclk, .reset, .shared_irq, .mask(16'h0C00), .ack, .flags,
    .pending);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_irq(input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: irq %b, want %b", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge mclk);
    #2;
  endtask
  task automatic bus(input logic [15:0] a, input logic [15:0] d, input logic wr);
    mmr_addr = a;
    mmr_wdata = d;
    mmr_wr = wr;
    mmr_rd = ~wr;
    step;
    mmr_wr = 1'h0;
    mmr_rd = 1'h0;
    // Idle edge so back-to-back calls never re-drive a strobe in one step
    step;
  endtask
  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (400) @(posedge mclk);
    n_mismatch++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) step;
    reset = 1'b0;
    bus(16'h0054, 16'h0000, 1'b0);
    cmp_word(mmr_rdata, dism_pkg::PREC_CTRL_RESET);
    cmp_word({14'h0, route_active}, 16'h0000);
    foreach (rows[i]) begin
      wdat = {8'h5A, rows[i].rt, 6'h15};
      bus(16'h0054, wdat, 1'b1);
      bus(16'h0054, 16'h0000, 1'b0);
      cmp_word(mmr_rdata, wdat);
      cmp_word({14'h0, route_active}, {14'h0, (rows[i].rt == 2'h3) ? 2'h0 : rows[i].rt});
      dma_ch_irq = rows[i].dma;
      legacy_irq = rows[i].leg;
      step;
      cmp_irq({shared_irq, dma_ch5_req, dma_ch4_req}, {rows[i].exp, rows[i].dma[5:4]});
    end
    // Unmapped address must not disturb the register
    bus(16'h0055, 16'h0080, 1'b1);
    bus(16'h0054, 16'h0000, 1'b0);
    cmp_word(mmr_rdata, wdat);
    bus(16'h0055, 16'h0000, 1'b0);
    cmp_word(mmr_rdata, 16'h0000);
    // One-cycle pulse on channel 2 with serial routing; flags cleared first
    legacy_irq = 4'h0;
    dma_ch_irq = 6'h00;
    ack = 1'h1;
    step;
    ack = 1'h0;
    bus(16'h0054, 16'h0040, 1'h1);
    dma_ch_irq = 6'h04;
    step;
    dma_ch_irq = 6'h00;
    cmp_irq({shared_irq, dma_ch5_req, dma_ch4_req}, 6'h08);
    step;
    cmp_irq({shared_irq, dma_ch5_req, dma_ch4_req}, 6'h00);
    cmp_word(flags, 16'h0400);
    cmp_word({15'h0000, pending}, 16'h0001);
    // Clock enable low freezes the outputs and refuses a register write
    dma_ch_irq = 6'h08;
    step;
    ce = 1'h0;
    dma_ch_irq = 6'h00;
    bus(16'h0054, 16'h0080, 1'h1);
    cmp_irq({shared_irq, dma_ch5_req, dma_ch4_req}, 6'h04);
    ce = 1'h1;
    bus(16'h0054, 16'h0000, 1'h0);
    cmp_word(mmr_rdata, 16'h0040);
    // Second reset clears live outputs and restores legacy routing
    legacy_irq = 4'hF;
    dma_ch_irq = 6'h30;
    reset = 1'h1;
    step;
    cmp_irq({shared_irq, dma_ch5_req, dma_ch4_req}, 6'h00);
    reset = 1'h0;
    bus(16'h0054, 16'h0000, 1'b0);
    cmp_word(mmr_rdata, 16'h0000);
    cmp_word({14'h0, route_active}, 16'h0000);
    end_of_test;
  end
endmodule
